// ===== design/loch_consts.svh
// constants of the loop operation command handler
`ifndef LOCH_CONSTS_SVH
`define LOCH_CONSTS_SVH
`define LOCH_OFF_OUTW 8'h00
`define LOCH_OFF_INW 8'h04
`define LOCH_OFF_LOOPST 8'h08
`define LOCH_OFF_CFG 8'h0C
`define LOCH_OFF_ISTAT 8'h10
`define LOCH_OFF_IMASK 8'h14
`define LOCH_NIB_CMD 4'hC
`define LOCH_OP_RUNSTOP 4'hC
`define LOCH_OP_MODE 4'hD
`define LOCH_OP_STORE 4'hE
`define LOCH_OP_TUNE 4'hF
`define LOCH_SUB_LOW 4'hC
`define LOCH_SUB_HIGH 4'hD
`define LOCH_LOOP_ALL 4'hA
`define LOCH_MASK_NONE 4'h0
`define LOCH_MASK_ALL 4'hF
`define LOCH_WR_SP 4'h0
`define LOCH_WR_NONE 4'h7
`define LOCH_RD_SP 4'h0
`define LOCH_RD_PV 4'h7
`define LOCH_STORE_SETPOINT_CMD 16'hCEEA
`define LOCH_TUNING_CONFLICT_ERROR 16'hEE00
`define LOCH_SETTING_ERROR 16'hEE01
`define LOCH_EV_ACK 0
`define LOCH_EV_ERR 1
`define LOCH_EV_STORED 2
`define LOCH_EV_TUNED 3
`define LOCH_CLK_HZ 125000000
`define LOCH_NVM_MS 60
`define LOCH_REFRESH_MS 500
`endif

// ===== design/loch_pkg.sv
// types of the loop operation command handler
package loch_pkg;
   typedef enum logic [1:0] {
      LOCH_IDLE = 2'h0,
      LOCH_WAIT_DATA = 2'h1,
      LOCH_MONITOR = 2'h3
   } loch_phase_t;
endpackage

// ===== design/loch_top.sv
// command interpreter of a four-loop temperature control unit
`timescale 1ns/1ps
`include "loch_consts.svh"

// Behaviour
// - An accepted command is echoed into the input word as its acknowledgement.
// - A value set by one command takes effect only when the following command is acknowledged.
// - Prefixes decode to stop, run, manual, auto, start and cancel tuning, plus the fixed store code, loops 1-4 or all.
// - After reset every loop is in auto mode and stopped.
// - An all-loops command runs on no loop if any loop fails its conditions; tuning commands then report a setting error, manual and auto the conflict code.
// - During tuning, manual, auto and parameter-writing allocation commands for that loop give the conflict code.
// - Start and cancel tuning need PID control in auto run, otherwise the setting error code is returned.
// - In manual mode the loop output comes from the manual value whether running or stopped.
// - A start-tuning command left standing restarts tuning each time it completes.
// - After a tuning start the handler is idle, so a data word is decoded as a command until a new allocation is accepted.
// - The store command writes the set point to non-volatile memory, busy for at least 60 ms.
// - A set-point-write, read-PV allocation is echoed, takes the next data word, then returns the process value.
// - While the output word stays unchanged after a monitor command the value is refreshed every 500 ms.
// - An unlisted command or loop digit returns the setting error code.
module loch_top #(
   parameter int unsigned NVM_CYC = `LOCH_NVM_MS * (`LOCH_CLK_HZ / 1000),
   parameter int unsigned REFRESH_CYC = `LOCH_REFRESH_MS * (`LOCH_CLK_HZ / 1000)
) (
   input wire logic CORE_CLK,
   input wire logic NRST,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [3:0] TUNE_DONE,
   input wire logic [63:0] PV_IN,
   output logic [31:0] RDATA,
   output logic IRQ,
   output logic [3:0] LOOP_RUN,
   output logic [3:0] LOOP_MANUAL,
   output logic [3:0] LOOP_TUNING,
   output logic [63:0] SP_OUT,
   output logic NVM_STORE,
   output logic NVM_BUSY
);
   // the store-busy check below needs at least eight busy cycles
   if (NVM_CYC < 8 || REFRESH_CYC < 2) begin : g_bad_cycles
      $error("loch_top: cycle counts too small");
   end

   logic rst_s1, rst_n;
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         rst_s1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n <= rst_s1;
      end
   end

   loch_pkg::loch_phase_t phase_reg, phase_next;
   logic [15:0] outw_reg, outw_next, inw_reg, inw_next, alloc_reg, alloc_next, spp_reg, spp_next;
   logic new_reg, new_next, spp_v_reg, spp_v_next, nvm_st_reg, nvm_st_next, busy_reg, busy_next;
   logic irq_reg, irq_next;
   logic [1:0] spp_i_reg, spp_i_next;
   logic [3:0] run_reg, run_next, man_reg, man_next, tune_reg, tune_next, stand_reg, stand_next;
   logic [3:0] cfg_reg, cfg_next, istat_reg, istat_next, imask_reg, imask_next;
   logic [63:0] sp_reg, sp_next;
   logic [31:0] nvm_cnt_reg, nvm_cnt_next, ref_reg, ref_next, rdata_reg, rdata_next;

   // decode of the word now in hand
   logic [15:0] w, mon;
   logic [3:0] lmask;
   logic [1:0] ai;
   logic any_tune, tune_ok, is_cmd, is_data;
   assign w = outw_reg;
   assign ai = alloc_reg[1:0] - 2'h1;
   assign any_tune = |(lmask & tune_reg);
   assign tune_ok = (lmask != `LOCH_MASK_NONE) && ((lmask & (cfg_reg | ~run_reg | man_reg)) == `LOCH_MASK_NONE);
   assign is_cmd = new_reg && phase_reg != loch_pkg::LOCH_WAIT_DATA;
   assign is_data = new_reg && phase_reg == loch_pkg::LOCH_WAIT_DATA;

   always_comb begin
      case (w[3:0])
         4'h1: lmask = 4'h1;
         4'h2: lmask = 4'h2;
         4'h3: lmask = 4'h4;
         4'h4: lmask = 4'h8;
         `LOCH_LOOP_ALL: lmask = `LOCH_MASK_ALL;
         default: lmask = `LOCH_MASK_NONE;
      endcase
   end

   always_comb begin
      case (alloc_reg[7:4])
         `LOCH_RD_PV: mon = PV_IN[{ai, 4'h0} +: 16];
         `LOCH_RD_SP: mon = sp_reg[{ai, 4'h0} +: 16];
         default: mon = 16'h0000;
      endcase
   end

   always_comb begin
      logic ok;
      logic [15:0] code;
      logic [3:0] ev;
      ok = 1'b1;
      code = `LOCH_SETTING_ERROR;
      ev = 4'h0;
      phase_next = phase_reg;
      outw_next = outw_reg;
      new_next = 1'b0;
      inw_next = inw_reg;
      alloc_next = alloc_reg;
      spp_next = spp_reg;
      spp_v_next = spp_v_reg;
      spp_i_next = spp_i_reg;
      run_next = run_reg;
      man_next = man_reg;
      tune_next = tune_reg;
      stand_next = stand_reg;
      cfg_next = cfg_reg;
      imask_next = imask_reg;
      sp_next = sp_reg;
      nvm_cnt_next = nvm_cnt_reg;
      nvm_st_next = 1'b0;
      ref_next = ref_reg;
      rdata_next = 32'h0000_0000;
      if (WR && ADDR == `LOCH_OFF_OUTW && WDATA[15:0] != outw_reg) begin
         outw_next = WDATA[15:0];
         new_next = 1'b1;
      end
      if (WR && ADDR == `LOCH_OFF_CFG) begin
         cfg_next = WDATA[3:0];
      end
      if (WR && ADDR == `LOCH_OFF_IMASK) begin
         imask_next = WDATA[3:0];
      end
      for (int i = 0; i < 4; i++) begin
         if (TUNE_DONE[i] && tune_reg[i]) begin
            ev[`LOCH_EV_TUNED] = 1'b1;
            if (!stand_reg[i]) begin
               tune_next[i] = 1'b0; // a standing start keeps tuning
            end
         end
      end
      if (nvm_cnt_reg != 32'h0) begin
         nvm_cnt_next = nvm_cnt_reg - 32'h1;
         if (nvm_cnt_reg == 32'h1) begin
            ev[`LOCH_EV_STORED] = 1'b1;
         end
      end
      if (phase_reg == loch_pkg::LOCH_MONITOR) begin
         if (ref_reg == REFRESH_CYC - 1) begin
            inw_next = mon;
            ref_next = 32'h0;
         end else begin
            ref_next = ref_reg + 32'h1;
         end
      end
      if (is_data) begin
         // data word belongs to the allocation accepted immediately before it
         if (alloc_reg[11:8] == `LOCH_WR_SP) begin
            spp_next = w;
            spp_v_next = 1'b1;
            spp_i_next = ai;
         end
         inw_next = mon;
         phase_next = loch_pkg::LOCH_MONITOR;
         ref_next = 32'h0;
         ev[`LOCH_EV_ACK] = 1'b1;
      end else if (is_cmd) begin
         phase_next = loch_pkg::LOCH_IDLE;
         stand_next = `LOCH_MASK_NONE;
         if (w == `LOCH_STORE_SETPOINT_CMD) begin
            nvm_cnt_next = NVM_CYC;
            nvm_st_next = 1'b1;
         end else if (w[15:12] != `LOCH_NIB_CMD || lmask == `LOCH_MASK_NONE) begin
            ok = 1'b0;
         end else begin
            case (w[11:8])
               `LOCH_OP_RUNSTOP: begin
                  if (w[7:4] == `LOCH_SUB_LOW) begin
                     run_next = run_reg & ~lmask;
                     tune_next = tune_next & ~lmask;
                  end else if (w[7:4] == `LOCH_SUB_HIGH) begin
                     run_next = run_reg | lmask;
                  end else begin
                     ok = 1'b0;
                  end
               end
               `LOCH_OP_MODE: begin
                  if (any_tune) begin
                     ok = 1'b0;
                     code = `LOCH_TUNING_CONFLICT_ERROR;
                  end else if (w[7:4] == `LOCH_SUB_LOW) begin
                     man_next = man_reg | lmask;
                  end else if (w[7:4] == `LOCH_SUB_HIGH) begin
                     man_next = man_reg & ~lmask;
                  end else begin
                     ok = 1'b0;
                  end
               end
               `LOCH_OP_TUNE: begin
                  // every addressed loop must qualify, so all-loops is all or none
                  if (!tune_ok) begin
                     ok = 1'b0;
                  end else if (w[7:4] == `LOCH_SUB_LOW) begin
                     tune_next = tune_next | lmask;
                     stand_next = lmask;
                  end else if (w[7:4] == `LOCH_SUB_HIGH) begin
                     tune_next = tune_next & ~lmask;
                  end else begin
                     ok = 1'b0;
                  end
               end
               `LOCH_OP_STORE: begin
                  ok = 1'b0;
               end
               default: begin
                  if (lmask == `LOCH_MASK_ALL) begin
                     ok = 1'b0;
                  end else if (w[11:8] != `LOCH_WR_NONE && any_tune) begin
                     ok = 1'b0;
                     code = `LOCH_TUNING_CONFLICT_ERROR;
                  end else begin
                     alloc_next = w;
                     phase_next = loch_pkg::LOCH_WAIT_DATA;
                  end
               end
            endcase
         end
         if (ok) begin
            inw_next = w;
            ev[`LOCH_EV_ACK] = 1'b1;
            if (spp_v_reg) begin
               sp_next[{spp_i_reg, 4'h0} +: 16] = spp_reg;
               spp_v_next = 1'b0;
            end
         end else begin
            inw_next = code;
            ev[`LOCH_EV_ERR] = 1'b1;
            run_next = run_reg;
            man_next = man_reg;
            stand_next = `LOCH_MASK_NONE;
         end
      end
      // set wins over a write-one clear in the same cycle
      istat_next = istat_reg & ~((WR && ADDR == `LOCH_OFF_ISTAT) ? WDATA[3:0] : 4'h0);
      istat_next = istat_next | ev;
      irq_next = |(istat_next & imask_next);
      busy_next = nvm_cnt_next != 32'h0;
      if (RD) begin
         if (ADDR == `LOCH_OFF_OUTW) begin
            rdata_next = {16'h0000, outw_reg};
         end else if (ADDR == `LOCH_OFF_INW) begin
            rdata_next = {16'h0000, inw_reg};
         end else if (ADDR == `LOCH_OFF_LOOPST) begin
            rdata_next = {19'h0, busy_reg, tune_reg, man_reg, run_reg};
         end else if (ADDR == `LOCH_OFF_CFG) begin
            rdata_next = {28'h0, cfg_reg};
         end else if (ADDR == `LOCH_OFF_ISTAT) begin
            rdata_next = {28'h0, istat_reg};
         end else if (ADDR == `LOCH_OFF_IMASK) begin
            rdata_next = {28'h0, imask_reg};
         end else begin
            rdata_next = 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         phase_reg <= loch_pkg::LOCH_IDLE;
         outw_reg <= '0;
         new_reg <= 1'b0;
         inw_reg <= '0;
         alloc_reg <= '0;
         spp_reg <= '0;
         spp_v_reg <= 1'b0;
         spp_i_reg <= '0;
         run_reg <= '0; // stopped
         man_reg <= '0; // auto
         tune_reg <= '0;
         stand_reg <= '0;
         cfg_reg <= '0;
         istat_reg <= '0;
         imask_reg <= '0;
         sp_reg <= '0;
         nvm_cnt_reg <= '0;
         nvm_st_reg <= 1'b0;
         busy_reg <= 1'b0;
         ref_reg <= '0;
         rdata_reg <= '0;
         irq_reg <= 1'b0;
      end else begin
         phase_reg <= phase_next;
         outw_reg <= outw_next;
         new_reg <= new_next;
         inw_reg <= inw_next;
         alloc_reg <= alloc_next;
         spp_reg <= spp_next;
         spp_v_reg <= spp_v_next;
         spp_i_reg <= spp_i_next;
         run_reg <= run_next;
         man_reg <= man_next;
         tune_reg <= tune_next;
         stand_reg <= stand_next;
         cfg_reg <= cfg_next;
         istat_reg <= istat_next;
         imask_reg <= imask_next;
         sp_reg <= sp_next;
         nvm_cnt_reg <= nvm_cnt_next;
         nvm_st_reg <= nvm_st_next;
         busy_reg <= busy_next;
         ref_reg <= ref_next;
         rdata_reg <= rdata_next;
         irq_reg <= irq_next;
      end
   end

   assign RDATA = rdata_reg;
   assign IRQ = irq_reg;
   assign LOOP_RUN = run_reg;
   assign LOOP_MANUAL = man_reg; // output stage takes manual value in either run state
   assign LOOP_TUNING = tune_reg;
   assign SP_OUT = sp_reg;
   assign NVM_STORE = nvm_st_reg;
   assign NVM_BUSY = busy_reg;

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!rst_n);

   sequence s_cmd;
      new_reg && phase_reg != loch_pkg::LOCH_WAIT_DATA;
   endsequence
   sequence s_data;
      new_reg && phase_reg == loch_pkg::LOCH_WAIT_DATA;
   endsequence

   a_run_all_echo: assert property (s_cmd ##0 (w == 16'hCCDA) |=> run_reg == 4'hF && inw_reg == 16'hCCDA)
      else $error("run all not echoed");
   a_power_up: assert property ($rose(rst_n) |-> run_reg == 4'h0 && man_reg == 4'h0)
      else $error("loops not stopped in auto after reset");
   a_all_or_none: assert property (s_cmd ##0 (w[15:4] == 12'hCFC && !tune_ok)
      |=> inw_reg == `LOCH_SETTING_ERROR
      && tune_reg == ($past(tune_reg) & ~($past(TUNE_DONE) & ~$past(stand_reg))))
      else $error("tuning started on a failing loop set");
   a_mode_conflict: assert property (s_cmd ##0 (w[15:8] == 8'hCD && any_tune)
      |=> inw_reg == `LOCH_TUNING_CONFLICT_ERROR && $stable(man_reg))
      else $error("mode change during tuning");
   a_tune_cond: assert property ($rose(tune_reg[0]) |->
      $past(run_reg[0]) && !$past(man_reg[0]) && !$past(cfg_reg[0]))
      else $error("tuning began outside auto run");
   a_sp_deferred: assert property (s_data |=> $stable(sp_reg))
      else $error("set point changed before next acknowledgement");
   a_data_answer: assert property (s_data ##0 (alloc_reg[7:4] == `LOCH_RD_PV)
      |=> phase_reg == loch_pkg::LOCH_MONITOR && inw_reg == $past(mon))
      else $error("data word not answered with process value");
   a_store_busy: assert property (nvm_st_reg |-> busy_reg [*8])
      else $error("store busy dropped early");
   a_refresh: assert property (phase_reg == loch_pkg::LOCH_MONITOR && ref_reg == REFRESH_CYC - 1
      && !new_reg |=> inw_reg == $past(mon))
      else $error("monitor value not refreshed");
   a_once: assert property (new_reg && !WR |=> !new_reg)
      else $error("word processed twice");
   a_retune: assert property (stand_reg[0] && tune_reg[0] && TUNE_DONE[0] && !new_reg |=> tune_reg[0])
      else $error("standing start did not restart tuning");
endmodule

// ===== sim/loch_host_model.sv
// host cpu model that drives the register bus of the command handler
`timescale 1ns/1ps
`include "loch_consts.svh"
module loch_host_model (
   input wire logic clk,
   output logic [7:0] addr,
   output logic [31:0] wdata,
   output logic wr,
   output logic rd,
   input wire logic [31:0] rdata
);
   initial begin
      addr = 8'h00;
      wdata = 32'h0000_0000;
      wr = 1'b0;
      rd = 1'b0;
   end

   // released data is inverted so a stale word never passes for a fresh one
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      wdata <= ~d;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      d = rdata;
   endtask

   task automatic send_word(input logic [15:0] w);
      wr_reg(`LOCH_OFF_OUTW, {16'h0000, w});
   endtask
endmodule

// ===== sim/tb.sv
// self-checking bench of the loop operation command handler
`timescale 1ns/1ps
`include "loch_consts.svh"
module tb;
   localparam int unsigned NVM_T = 20;
   localparam int unsigned REF_T = 16;
   logic CORE_CLK = 1'b0;
   logic NRST = 1'b0;
   logic [7:0] ADDR;
   logic [31:0] WDATA;
   logic WR;
   logic RD;
   logic [3:0] TUNE_DONE = 4'h0;
   logic [63:0] PV_IN = 64'h0;
   logic [31:0] RDATA;
   logic IRQ;
   logic [3:0] LOOP_RUN;
   logic [3:0] LOOP_MANUAL;
   logic [3:0] LOOP_TUNING;
   logic [63:0] SP_OUT;
   logic NVM_STORE;
   logic NVM_BUSY;
   int mismatches = 0;
   int check_count = 0;
   logic [15:0] lfsr = 16'h48A6;
   logic [3:0] run = 4'h0;
   logic [3:0] man = 4'h0;
   logic [3:0] tune = 4'h0;
   logic [3:0] cfg = 4'h0;
   logic [15:0] last = 16'h0000;
   logic [15:0] exp_inw = 16'h0000;
   logic [15:0] r;
   logic [15:0] w;
   logic [15:0] pv;
   logic [31:0] rv;
   logic [31:0] nb;
   logic [31:0] ns;

   always #4 CORE_CLK = ~CORE_CLK;

   loch_top #(.NVM_CYC(NVM_T), .REFRESH_CYC(REF_T)) dut (
      .CORE_CLK(CORE_CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .TUNE_DONE(TUNE_DONE), .PV_IN(PV_IN), .RDATA(RDATA), .IRQ(IRQ), .LOOP_RUN(LOOP_RUN),
      .LOOP_MANUAL(LOOP_MANUAL), .LOOP_TUNING(LOOP_TUNING), .SP_OUT(SP_OUT),
      .NVM_STORE(NVM_STORE), .NVM_BUSY(NVM_BUSY)
   );

   loch_host_model host (
      .clk(CORE_CLK), .addr(ADDR), .wdata(WDATA), .wr(WR), .rd(RD), .rdata(RDATA)
   );

   function automatic logic [15:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr;
   endfunction

   // expected answer of an operation word; updates the loop state model
   function automatic logic [15:0] exp_cmd(input logic [15:0] c);
      logic [3:0] m;
      m = 4'h0;
      if (c == `LOCH_STORE_SETPOINT_CMD) return c;
      if (c[3:0] >= 4'h1 && c[3:0] <= 4'h4) m = 4'h1 << (c[3:0] - 4'h1);
      if (c[3:0] == `LOCH_LOOP_ALL) m = 4'hF;
      if (m == 4'h0 || c[15:12] != 4'hC || (c[7:4] != 4'hC && c[7:4] != 4'hD)) return `LOCH_SETTING_ERROR;
      case (c[11:8])
         `LOCH_OP_RUNSTOP: begin
            // stopping a loop also ends its tuning
            if (c[4]) run = run | m;
            else begin
               run = run & ~m;
               tune = tune & ~m;
            end
         end
         `LOCH_OP_MODE: begin
            if ((tune & m) != 4'h0) return `LOCH_TUNING_CONFLICT_ERROR;
            if (c[4]) man = man & ~m;
            else man = man | m;
         end
         `LOCH_OP_TUNE: begin
            if ((m & (cfg | ~run | man)) != 4'h0) return `LOCH_SETTING_ERROR;
            if (c[4]) tune = tune & ~m;
            else tune = tune | m;
         end
         default: return `LOCH_SETTING_ERROR;
      endcase
      return c;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      if (mismatches == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic put(input logic [15:0] c);
      host.send_word(c);
      last = c;
      @(posedge CORE_CLK);
   endtask

   task automatic rd_inw(input logic [15:0] e);
      host.rd_reg(`LOCH_OFF_INW, rv);
      check(rv, {16'h0000, e});
   endtask

   task automatic cmd(input logic [15:0] c);
      if (c !== last) exp_inw = exp_cmd(c);
      put(c);
      host.rd_reg(`LOCH_OFF_INW, rv);
      check(rv, {16'h0000, exp_inw});
      host.rd_reg(`LOCH_OFF_LOOPST, rv);
      check({20'h0, rv[11:0]}, {20'h0, tune, man, run});
      check({20'h0, LOOP_TUNING, LOOP_MANUAL, LOOP_RUN}, {20'h0, tune, man, run});
   endtask

   task automatic pulse_done();
      @(posedge CORE_CLK);
      TUNE_DONE <= 4'h1;
      @(posedge CORE_CLK);
      TUNE_DONE <= 4'h0;
      repeat (3) @(posedge CORE_CLK);
   endtask

   initial begin
      repeat (30000) @(posedge CORE_CLK);
      mismatches++;
      finish_test();
   end

   initial begin
      repeat (6) @(posedge CORE_CLK);
      NRST <= 1'b1;
      repeat (3) @(posedge CORE_CLK);
      check({20'h0, LOOP_TUNING, LOOP_MANUAL, LOOP_RUN}, 32'h0);
      host.rd_reg(8'h20, rv);
      check(rv, 32'h0);
      host.wr_reg(`LOCH_OFF_IMASK, 32'h1);
      cmd(16'hCCDA);
      check({31'h0, IRQ}, 32'h1);
      host.wr_reg(`LOCH_OFF_ISTAT, 32'hF);
      repeat (2) @(posedge CORE_CLK);
      check({31'h0, IRQ}, 32'h0);
      host.wr_reg(`LOCH_OFF_IMASK, 32'h0);
      for (int i = 0; i < 80; i++) begin
         r = rnd();
         if (r[3:0] == 4'h0 && tune == 4'h0) begin
            cfg = r[11:8];
            host.wr_reg(`LOCH_OFF_CFG, {28'h0, cfg});
         end
         w[15:12] = 4'hC;
         w[11:8] = (r[1:0] == 2'h0) ? `LOCH_OP_RUNSTOP : (r[1:0] == 2'h1) ? `LOCH_OP_MODE : `LOCH_OP_TUNE;
         w[7:4] = r[2] ? `LOCH_SUB_HIGH : `LOCH_SUB_LOW;
         w[3:0] = (r[6:4] < 3'h4) ? {1'b0, r[6:4]} + 4'h1 : (r[6:4] == 3'h6) ? 4'h5 : `LOCH_LOOP_ALL;
         if (r[15:13] == 3'h0) w = last;
         cmd(w);
      end
      cmd(16'hCCCA);
      cmd(16'hCDDA);
      put(16'hC071);
      rd_inw(16'hC071);
      pv = rnd();
      PV_IN[15:0] <= pv;
      put(16'h0100);
      rd_inw(pv);
      check({16'h0, SP_OUT[15:0]}, 32'h0);
      pv = rnd();
      PV_IN[15:0] <= pv;
      repeat (REF_T + 4) @(posedge CORE_CLK);
      rd_inw(pv);
      cmd(16'hCCD1);
      check({16'h0, SP_OUT[15:0]}, 32'h0100);
      // read-only allocation of the committed set point of loop 1
      put(16'hC701);
      rd_inw(16'hC701);
      put(16'h0000);
      rd_inw(16'h0100);
      cfg = 4'h0;
      host.wr_reg(`LOCH_OFF_CFG, 32'h0);
      cmd(16'hCFC1);
      pulse_done();
      check({31'h0, LOOP_TUNING[0]}, 32'h1);
      host.rd_reg(`LOCH_OFF_ISTAT, rv);
      check({31'h0, rv[`LOCH_EV_TUNED]}, 32'h1);
      cmd(16'hCDC1);
      put(16'hC071);
      rd_inw(`LOCH_TUNING_CONFLICT_ERROR);
      // start word no longer stands since the mode word; host sends a read-only allocation
      put(16'hC771);
      rd_inw(16'hC771);
      put(16'h0000);
      pulse_done();
      tune = 4'h0;
      check({31'h0, LOOP_TUNING[0]}, 32'h0);
      cfg = 4'h1;
      host.wr_reg(`LOCH_OFF_CFG, 32'h1);
      cmd(16'hCFC1);
      cmd(16'hCFCA);
      put(`LOCH_STORE_SETPOINT_CMD);
      nb = 32'h0;
      ns = 32'h0;
      for (int i = 0; i < 60; i++) begin
         @(negedge CORE_CLK);
         nb = nb + {31'h0, NVM_BUSY};
         ns = ns + {31'h0, NVM_STORE};
      end
      check(nb, NVM_T);
      check(ns, 32'h1);
      rd_inw(`LOCH_STORE_SETPOINT_CMD);
      finish_test();
   end
endmodule
